/* hdl/vsi_slave.sv */
// a16/d16 register slave with delayed acknowledge and d16 interrupter
// assumes all bus pins asynchronous; outputs go to open-collector buffers
// Notes on behaviour
// - a1..a15 select logical address and register
// - answer upper quarter, 255 switch addresses
// - register cycles respond only to modifier 29 or 2d; interrupt acknowledge ignores the modifier
// - a16 addressing, d16 data only
// - data lines buffered to internal word bus
// - status read: extended-n and passed flags
// - spare status bits from user inputs
// - identity read: maker, class, a16 mode
// - model code read from switches
// - control write: soft reset, sysfail inhibit
// - spare control bits drive user outputs
// - three registers read only, control write only
// - acknowledge only after deliberate delay
// - d16 interrupter, status id on acknowledge
// - one jumpered active-low request line
// - pass acknowledge down chain when not ours
// - bus or soft reset clears the control register and the interrupter
// - names ending _n are active low
`timescale 1ns/1ps
`include "vsi_cfg.svh"
module vsi_slave
   import vsi_pkg::*;
#(
   parameter logic [11:0] MAKER_ID = 12'h5a5   // arbitrary value
)
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        sysreset_n,
   input  wire logic [15:1] addr,
   input  wire logic [5:0]  am,
   input  wire logic        as_n,
   input  wire logic        ds0_n,
   input  wire logic        ds1_n,
   input  wire logic        write_n,
   input  wire logic        iack_n,
   input  wire logic        iackin_n,
   input  wire logic [15:0] data_in,
   output logic      [15:0] data_out,
   output logic             data_oe_n,
   output logic             dtack_n,
   output logic             iackout_n,
   output logic      [7:1]  irq_n,
   output logic             sysfail_n,
   input  wire logic [7:0]  laddr_sw,
   input  wire logic [7:0]  model_sw,
   input  wire logic [2:0]  irq_level_jmp,
   input  wire logic [7:0]  status_id_sw,
   input  wire logic        passed,
   input  wire logic [1:0]  user_status,
   input  wire logic        user_irq,
   output logic      [5:0]  user_ctrl,
   output logic             user_rst
);
   import vsi_pkg::*;

   // pin synchronisers: all of the bus is asynchronous
   logic [15:1] addr_s;
   logic [5:0]  am_s;
   logic [15:0] din_s;
   logic [6:0]  ctl_s;
   logic [7:0]  laddr_s, model_s, stid_s;
   logic [2:0]  lvl_s;
   logic [3:0]  usr_s;
   vsi_sync #(.W(15)) u_sa (.clk(clk), .nrst(nrst), .d(addr), .q(addr_s));
   vsi_sync #(.W(6))  u_sm (.clk(clk), .nrst(nrst), .d(am), .q(am_s));
   vsi_sync #(.W(16)) u_sd (.clk(clk), .nrst(nrst), .d(data_in), .q(din_s));
   vsi_sync #(.W(7))  u_sc (.clk(clk), .nrst(nrst),
      .d(~{sysreset_n, as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n}), .q(ctl_s));
   vsi_sync #(.W(8))  u_sl (.clk(clk), .nrst(nrst), .d(laddr_sw), .q(laddr_s));
   vsi_sync #(.W(8))  u_so (.clk(clk), .nrst(nrst), .d(model_sw), .q(model_s));
   vsi_sync #(.W(8))  u_si (.clk(clk), .nrst(nrst), .d(status_id_sw), .q(stid_s));
   vsi_sync #(.W(3))  u_sj (.clk(clk), .nrst(nrst), .d(irq_level_jmp), .q(lvl_s));
   vsi_sync #(.W(4))  u_su (.clk(clk), .nrst(nrst),
      .d({passed, user_status, user_irq}), .q(usr_s));

   logic sysrst_ns, as_ns, ds0_ns, ds1_ns, wr_ns, iack_ns, iackin_ns;
   // control pins inverted: a cleared flop must read as an idle high pin, no false cycle after reset
   assign {sysrst_ns, as_ns, ds0_ns, ds1_ns, wr_ns, iack_ns, iackin_ns} = ~ctl_s;

   // strobes only, data strobes gate the cycle
   logic ds_any;
   logic ds_both;
   assign ds_any  = !ds0_ns || !ds1_ns;
   assign ds_both = !ds0_ns && !ds1_ns;

   // board select from a6..a15
   function automatic logic addr_hit(input logic [15:1] a, input logic [7:0] la);
      addr_hit = (a[15:14] == `VSI_A16_TOP_BITS) && (la != `VSI_LADDR_NONE)
                 && (a[13:6] == la);
   endfunction : addr_hit

   function automatic logic am_ok(input logic [5:0] m);
      am_ok = (m == `VSI_AM_A16_NPRIV) || (m == `VSI_AM_A16_SUPER);
   endfunction : am_ok

   logic        own_ack;
   logic        irq_pend;
   logic        srst_reg, srst_next;
   logic [3:0]  srst_cnt_reg, srst_cnt_next;
   logic        rst_any;

   // reset fan-in: bus reset level or soft-reset pulse stretch
   assign rst_any = !sysrst_ns || srst_reg;

   vsi_irq u_irq (
      .clk      (clk),
      .nrst     (nrst),
      .soft_rst (rst_any),
      .user_irq (usr_s[0]),
      .own_ack  (own_ack),
      .pending  (irq_pend)
   );

   // bus cycle state
   vsi_bus_type st_reg, st_next;
   logic [7:0]  dly_reg, dly_next;
   logic [15:0] dout_reg, dout_next;
   logic        oe_n_reg, oe_n_next;
   logic        dtack_n_reg, dtack_n_next;
   logic        iackout_n_reg, iackout_n_next;
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [15:0] rd_word;
   logic        sel;
   logic        wr_cyc;

   assign sel    = addr_hit(addr_s, laddr_s) && am_ok(am_s) && iack_ns && !as_ns;
   assign wr_cyc = !wr_ns;

   // readback mux over the internal word bus
   always_comb
   begin
      rd_word = 16'h0000;
      unique case (addr_s[5:1])
         `VSI_REG_IDENT:
            rd_word = {`VSI_IDENT_CLASS_REG, `VSI_IDENT_ADDR_MODE, MAKER_ID};
         `VSI_REG_TYPE:
            rd_word = {8'hff, model_s};
         `VSI_REG_STATUS_CTRL:
            rd_word = {8'hff, 2'h3, usr_s[2:1], 1'h1, usr_s[3], 2'h3};
         default:
            rd_word = 16'hffff;
      endcase
   end

   always_comb
   begin
      st_next        = st_reg;
      dly_next       = dly_reg;
      dout_next      = dout_reg;
      oe_n_next      = oe_n_reg;
      dtack_n_next   = dtack_n_reg;
      iackout_n_next = iackout_n_reg;
      ctrl_next      = ctrl_reg;
      own_ack        = 1'b0;
      unique case (st_reg)
         VSI_IDLE:
         begin
            dtack_n_next   = 1'b1;
            oe_n_next      = 1'b1;
            iackout_n_next = 1'b1;
            if (!iack_ns && !as_ns && ds_any && !iackin_ns)
            begin
               // claim only when pending and the level matches a[3:1]
               if (irq_pend && (addr_s[3:1] == lvl_s))
               begin
                  own_ack   = 1'b1;
                  dout_next = {8'h00, stid_s};
                  oe_n_next = 1'b0;
                  dly_next  = 8'h00;
                  st_next   = VSI_IACK;
               end
               else
               begin
                  iackout_n_next = 1'b0;
                  st_next        = VSI_PASS;
               end
            end
            else if (sel && ds_any)
            begin
               // d16 only: single-byte strobes are acknowledged, but a control write needs both strobes
               dly_next = 8'h00;
               if (wr_cyc)
               begin
                  if (addr_s[5:1] == `VSI_REG_STATUS_CTRL && ds_both)
                     ctrl_next = din_s[7:0];
               end
               else
               begin
                  dout_next = rd_word;
                  oe_n_next = 1'b0;
               end
               st_next = VSI_WAIT;
            end
         end
         VSI_WAIT, VSI_IACK:
         begin
            // settle time before acknowledging
            dly_next = dly_reg + 8'h01;
            if (dly_reg == 8'(`VSI_DTACK_CYCLES - 1))
            begin
               dtack_n_next = 1'b0;
               st_next      = VSI_ACK;
            end
         end
         VSI_ACK:
         begin
            if (!ds_any)
            begin
               dtack_n_next = 1'b1;
               oe_n_next    = 1'b1;
               st_next      = VSI_IDLE;
            end
         end
         VSI_PASS:
         begin
            if (as_ns || iackin_ns)
            begin
               iackout_n_next = 1'b1;
               st_next        = VSI_IDLE;
            end
         end
         default:
            st_next = VSI_IDLE;
      endcase
      if (rst_any)
         ctrl_next = `VSI_CT_RESET_VAL;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg        <= VSI_IDLE;
         dly_reg       <= 8'h00;
         dout_reg      <= 16'h0000;
         oe_n_reg      <= 1'b1;
         dtack_n_reg   <= 1'b1;
         iackout_n_reg <= 1'b1;
         ctrl_reg      <= `VSI_CT_RESET_VAL;
      end
      else
      begin
         st_reg        <= st_next;
         dly_reg       <= dly_next;
         dout_reg      <= dout_next;
         oe_n_reg      <= oe_n_next;
         dtack_n_reg   <= dtack_n_next;
         iackout_n_reg <= iackout_n_next;
         ctrl_reg      <= ctrl_next;
      end
   end

   // soft reset: the bit self-clears through the stretched pulse
   always_comb
   begin
      srst_next     = srst_reg;
      srst_cnt_next = srst_cnt_reg;
      if (ctrl_reg[`VSI_CT_RESET_BIT] && !srst_reg)
      begin
         srst_next     = 1'b1;
         srst_cnt_next = 4'h0;
      end
      else if (srst_reg)
      begin
         srst_cnt_next = srst_cnt_reg + 4'h1;
         if (srst_cnt_reg == 4'(`VSI_SRST_CYCLES - 1))
            srst_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         srst_reg     <= 1'b0;
         srst_cnt_reg <= 4'h0;
      end
      else
      begin
         srst_reg     <= srst_next;
         srst_cnt_reg <= srst_cnt_next;
      end
   end

   // registered side outputs
   logic [7:1] irq_n_reg;
   logic       sysfail_n_reg;
   logic [5:0] uctrl_reg;
   logic       urst_reg;
   logic       test_fail;
   assign test_fail = !usr_s[3];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_n_reg     <= 7'h7f;
         sysfail_n_reg <= 1'b1;
         uctrl_reg     <= 6'h00;
         urst_reg      <= 1'b1;
      end
      else
      begin
         for (int i = 1; i <= 7; i++)
            irq_n_reg[i] <= !(irq_pend && (lvl_s == 3'(i)));
         sysfail_n_reg <= !(test_fail && !ctrl_reg[`VSI_CT_SFINH_BIT]);
         uctrl_reg     <= ctrl_reg[7:2];
         urst_reg      <= rst_any;
      end
   end

   assign data_out  = dout_reg;
   assign data_oe_n = oe_n_reg;
   assign dtack_n   = dtack_n_reg;
   assign iackout_n = iackout_n_reg;
   assign irq_n     = irq_n_reg;
   assign sysfail_n = sysfail_n_reg;
   assign user_ctrl = uctrl_reg;
   assign user_rst  = urst_reg;

   // checks
   AST_NO_EARLY_ACK: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg == VSI_IDLE && st_next == VSI_WAIT) |-> dtack_n[*8])
      else $error("acknowledge came before the delay");
   AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      (!dtack_n && ds_any && st_reg == VSI_ACK) |=> !dtack_n)
      else $error("acknowledge dropped while strobes held");
   AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg == VSI_ACK && !ds_any) |=> (dtack_n && data_oe_n))
      else $error("acknowledge not released after strobes");
   AST_ACK_BOUND: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg == VSI_WAIT) |-> ##[1:12] (st_reg == VSI_ACK))
      else $error("acknowledge never came");
   AST_BAD_AM: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg == VSI_IDLE && iack_ns && !am_ok(am_s)) |=> st_reg != VSI_WAIT)
      else $error("responded to a foreign modifier");
   AST_PASS_ON: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg == VSI_IDLE && !iack_ns && !as_ns && ds_any && !iackin_ns
       && !(irq_pend && (addr_s[3:1] == lvl_s)))
      |=> !iackout_n)
      else $error("acknowledge not passed down chain");
   AST_IRQ_DROP: assert property (@(posedge clk) disable iff (!nrst)
      own_ack |=> ##1 (irq_n == 7'h7f))
      else $error("request not withdrawn after acknowledge");
   AST_SOFT_RST: assert property (@(posedge clk) disable iff (!nrst)
      $rose(srst_reg) |=> (ctrl_reg == `VSI_CT_RESET_VAL) ##1 user_rst)
      else $error("soft reset did not clear control");
   AST_SYSFAIL: assert property (@(posedge clk) disable iff (!nrst)
      (ctrl_reg[`VSI_CT_SFINH_BIT] && $stable(ctrl_reg)) |=> sysfail_n)
      else $error("sysfail shown while inhibited");
endmodule : vsi_slave

/* hdl/vsi_cfg.svh */
// constants for the a16 register slave
// assumes inclusion by vsi_pkg and design files only
`ifndef VSI_CFG_SVH
`define VSI_CFG_SVH
`define VSI_AM_A16_NPRIV    6'h29
`define VSI_AM_A16_SUPER    6'h2d
`define VSI_A16_TOP_BITS    2'h3
`define VSI_REG_IDENT       5'h00
`define VSI_REG_TYPE        5'h01
`define VSI_REG_STATUS_CTRL 5'h02
`define VSI_LADDR_NONE      8'hff
`define VSI_ST_PASSED_BIT   2
`define VSI_ST_EXT_N_BIT    3
`define VSI_CT_RESET_BIT    0
`define VSI_CT_SFINH_BIT    1
`define VSI_CT_RESET_VAL    8'h00
`define VSI_IDENT_ADDR_MODE 2'h3
`define VSI_IDENT_CLASS_REG 2'h3
`define VSI_DTACK_DELAY_NS  40
`define VSI_CLK_NS          4
`define VSI_DTACK_CYCLES    ((`VSI_DTACK_DELAY_NS + `VSI_CLK_NS - 1) / `VSI_CLK_NS)
`define VSI_SRST_CYCLES     8
`endif

/* hdl/vsi_pkg.sv */
// types for the a16 register slave
// assumes vsi_cfg.svh is on the include path
`include "vsi_cfg.svh"
package vsi_pkg;
   typedef enum logic [4:0] {
      VSI_IDLE  = 5'h01,
      VSI_WAIT  = 5'h02,
      VSI_ACK   = 5'h04,
      VSI_IACK  = 5'h08,
      VSI_PASS  = 5'h10
   } vsi_bus_type;
   typedef enum logic [2:0] {
      VSI_IRQ_OFF  = 3'h1,
      VSI_IRQ_REQ  = 3'h2,
      VSI_IRQ_DONE = 3'h4
   } vsi_irq_type;
endpackage : vsi_pkg

/* hdl/vsi_sync.sv */
// two flop synchroniser for a bus of pins
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module vsi_sync #(parameter int W = 1)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : vsi_sync

/* hdl/vsi_irq.sv */
// interrupt request state machine, one jumpered level
// assumes own_ack pulses when the bus fsm claims an acknowledge
`timescale 1ns/1ps
module vsi_irq
   import vsi_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       soft_rst,
   input  wire logic       user_irq,
   input  wire logic       own_ack,
   output logic            pending
);
   vsi_irq_type st_reg, st_next;
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg)
         VSI_IRQ_OFF:  if (user_irq) st_next = VSI_IRQ_REQ;
         VSI_IRQ_REQ:  if (own_ack) st_next = VSI_IRQ_DONE;
         VSI_IRQ_DONE: if (!user_irq) st_next = VSI_IRQ_OFF;
         default:      st_next = VSI_IRQ_OFF;
      endcase
      if (soft_rst)
         st_next = VSI_IRQ_OFF;
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st_reg <= VSI_IRQ_OFF;
      else
         st_reg <= st_next;
   end
   assign pending = (st_reg == VSI_IRQ_REQ);
endmodule : vsi_irq

/* verif/vsi_master.sv */
// bus master model driving the a16/d16 slave pins
// assumes tb calls cyc and the slave answers on dtack_n or iackout_n
`timescale 1ns/1ps
module vsi_master
(
   input  wire logic        clk,
   input  wire logic        dtack_n,
   input  wire logic        iackout_n,
   input  wire logic        data_oe_n,
   input  wire logic [15:0] data_out,
   output logic      [15:1] addr,
   output logic      [5:0]  am,
   output logic             as_n,
   output logic             ds0_n,
   output logic             ds1_n,
   output logic             write_n,
   output logic             iack_n,
   output logic             iackin_n,
   output logic      [15:0] data_in
);
   initial
   begin
      {as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n} = 6'h3f;
      addr = 15'h0000;
      am = 6'h00;
      data_in = 16'h0000;
   end
   // one word transfer; n is -1 when no acknowledge came
   task automatic cyc(input logic w, input logic ia, input logic [15:1] a,
                      input logic [5:0] m, input logic [15:0] d,
                      output logic [15:0] rd, output int n, output logic pass);
      int i;
      rd = 16'hxxxx;
      n = -1;
      pass = 1'b0;
      @(posedge clk);
      addr <= a;
      am <= m;
      write_n <= ~w;
      iack_n <= ~ia;
      iackin_n <= ~ia;
      data_in <= d;
      {as_n, ds0_n, ds1_n} <= 3'h0;
      for (i = 1; i <= 40 && n < 0 && !pass; i++)
      begin
         @(posedge clk);
         if (dtack_n === 1'b0)
         begin
            n = i;
            if (data_oe_n === 1'b0)
               rd = data_out;
         end
         else if (iackout_n === 1'b0)
            pass = 1'b1;
      end
      // released lines show the inverse, never a stale copy
      {as_n, ds0_n, ds1_n, iack_n, iackin_n} <= 5'h1f;
      data_in <= ~d;
      addr <= ~a;
      am <= ~m;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk);
         if (dtack_n === 1'b1 && iackout_n === 1'b1)
            break;
      end
   endtask : cyc
endmodule : vsi_master

/* verif/tb.sv */
// self-checking bench for the a16/d16 register slave
// assumes vsi_pkg compiled first and vsi_master as bus partner
`timescale 1ns/1ps
module tb;
   import vsi_pkg::*;
   localparam logic [7:0] LA  = 8'h42;
   localparam logic [7:0] MDL = 8'h3c;
   localparam logic [7:0] SID = 8'h96;
   logic        clk;
   logic        nrst;
   logic        sysreset_n;
   logic        passed;
   logic        user_irq;
   logic [15:1] addr;
   logic [5:0]  am;
   logic        as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n;
   logic [15:0] data_in, data_out;
   logic        data_oe_n, dtack_n, iackout_n, sysfail_n, user_rst;
   logic [7:1]  irq_n;
   logic [5:0]  user_ctrl;
   logic [15:0] v;
   logic        p;
   int          n, errors, total_checks, cycles;
   int          urst_cycles, urst_mark;

   vsi_slave vsi_slave_inst (.clk(clk), .nrst(nrst), .sysreset_n(sysreset_n), .addr(addr),
      .am(am), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n), .iack_n(iack_n),
      .iackin_n(iackin_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .dtack_n(dtack_n), .iackout_n(iackout_n), .irq_n(irq_n), .sysfail_n(sysfail_n),
      .laddr_sw(LA), .model_sw(MDL), .irq_level_jmp(3'h3), .status_id_sw(SID),
      .passed(passed), .user_status(2'h1), .user_irq(user_irq), .user_ctrl(user_ctrl),
      .user_rst(user_rst));
   vsi_master vsi_master_inst (.clk(clk), .dtack_n(dtack_n), .iackout_n(iackout_n),
      .data_oe_n(data_oe_n), .data_out(data_out), .addr(addr), .am(am), .as_n(as_n),
      .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n), .iack_n(iack_n),
      .iackin_n(iackin_n), .data_in(data_in));

   function automatic logic [15:1] ad(input logic [7:0] la, input logic [4:0] idx);
      return {2'h3, la, idx};
   endfunction : ad
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [5:0] m, input logic [15:1] a);
      vsi_master_inst.cyc(1'b0, 1'b0, a, m, 16'h0000, v, n, p);
   endtask : rd
   task automatic wr(input logic [15:1] a, input logic [15:0] d);
      vsi_master_inst.cyc(1'b1, 1'b0, a, 6'h29, d, v, n, p);
   endtask : wr
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      // reset pulse is shorter than one bus cycle, so it is counted here
      if (user_rst === 1'b1)
         urst_cycles++;
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   initial
   begin
      nrst = 1'b0;
      sysreset_n = 1'b1;
      passed = 1'b1;
      user_irq = 1'b0;
      repeat (2) @(posedge clk);
      chk({11'h000, dtack_n, data_oe_n, iackout_n, user_rst, sysfail_n}, 16'h001f);
      chk({3'h0, irq_n, user_ctrl}, 16'h1fc0);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd(6'h29, ad(LA, 5'h00));
      chk(v, 16'hf5a5);
      chk(16'(n >= 10), 16'h0001);
      chk(16'(data_oe_n), 16'h0001);
      rd(6'h2d, ad(LA, 5'h01));
      chk(v, {8'hff, MDL});
      rd(6'h29, ad(LA, 5'h02));
      chk(v, 16'hffdf);
      $display("test reads done");
      rd(6'h39, ad(LA, 5'h00));
      chk(n[15:0], 16'hffff);
      rd(6'h29, ad(LA ^ 8'h01, 5'h00));
      chk(n[15:0], 16'hffff);
      rd(6'h29, ad(LA, 5'h00) ^ 15'h4000);
      chk(n[15:0], 16'hffff);
      $display("test refusals done");
      passed <= 1'b0;
      repeat (6) @(posedge clk);
      chk(16'(sysfail_n), 16'h0000);
      wr(ad(LA, 5'h02), 16'h00a6);
      repeat (4) @(posedge clk);
      chk(16'(user_ctrl), 16'h0029);
      chk(16'(sysfail_n), 16'h0001);
      wr(ad(LA, 5'h00), 16'h0000);
      rd(6'h29, ad(LA, 5'h00));
      chk(v, 16'hf5a5);
      urst_mark = urst_cycles;
      wr(ad(LA, 5'h02), 16'h0001);
      chk(16'(urst_cycles - urst_mark), 16'h0008);
      repeat (12) @(posedge clk);
      chk({8'h00, user_ctrl, 1'b0, sysfail_n}, 16'h0000);
      wr(ad(LA, 5'h02), 16'h00a6);
      sysreset_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(user_rst), 16'h0001);
      sysreset_n <= 1'b1;
      repeat (12) @(posedge clk);
      chk(16'(user_ctrl), 16'h0000);
      $display("test control done");
      user_irq <= 1'b1;
      repeat (6) @(posedge clk);
      chk(16'(irq_n), 16'h007b);
      vsi_master_inst.cyc(1'b0, 1'b1, 15'h0005, 6'h29, 16'h0000, v, n, p);
      chk({p, n[14:0]}, 16'hffff);
      vsi_master_inst.cyc(1'b0, 1'b1, 15'h0003, 6'h29, 16'h0000, v, n, p);
      chk(v, {8'h00, SID});
      repeat (4) @(posedge clk);
      chk(16'(irq_n), 16'h007f);
      user_irq <= 1'b0;
      $display("test interrupt done");
      conclude();
   end
endmodule : tb
